// [rtl/vds_scaler.sv]
// video down-scaler: apb registers, horizontal polyphase and vertical line-store filter
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module vds_scaler
  import vds_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pixel stream in
  input wire logic in_valid,
  input wire logic in_line_start,
  input wire logic in_field_start,
  input wire logic in_field_odd,
  input wire logic [7:0] in_luma,
  input wire logic [7:0] in_chroma,
  // pixel stream out
  output logic out_valid,
  output logic out_line_start,
  output logic [7:0] out_luma,
  output logic [7:0] out_chroma
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and apb
  logic [7:0] vru_reg, vrl_reg, hru_reg, hrl_reg, vtc_reg, slc_reg;
  logic [9:0] line_px_reg;
  logic [9:0] in_lines_reg;
  logic [9:0] col_reg;
  logic [9:0] in_line_cnt_reg;
  logic [9:0] idx;
  logic hit;
  logic [7:0] rd_byte;
  logic [31:0] rd_word;

  assign idx = paddr[11:2];
  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    rd_byte = 8'h00;
    case (idx)
      {2'b00, VDS_IDX_VRU}: rd_byte = vru_reg;
      {2'b00, VDS_IDX_VRL}: rd_byte = vrl_reg;
      {2'b00, VDS_IDX_HRU}: rd_byte = hru_reg;
      {2'b00, VDS_IDX_HRL}: rd_byte = hrl_reg;
      {2'b00, VDS_IDX_VTC}: rd_byte = vtc_reg;
      {2'b00, VDS_IDX_SLC}: rd_byte = slc_reg;
      {2'b00, VDS_IDX_STA}: rd_word = {6'h00, in_lines_reg, 6'h00, line_px_reg};
      default: hit = 1'b0;
    endcase
    if (idx != {2'b00, VDS_IDX_STA}) begin
      rd_word = {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
      prdata <= (psel && !penable && !pwrite && hit) ? rd_word : 32'h0000_0000;
      pslverr <= psel && !penable && !hit;
    end
  end

  logic wr_go;
  assign wr_go = psel && penable && pready && pwrite && hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vru_reg <= VDS_RST_BYTE;
      vrl_reg <= VDS_RST_BYTE;
      hru_reg <= VDS_RST_BYTE;
      hrl_reg <= VDS_RST_BYTE;
      vtc_reg <= VDS_RST_BYTE;
      slc_reg <= VDS_RST_BYTE;
    end else if (wr_go) begin
      case (idx)
        {2'b00, VDS_IDX_VRU}: vru_reg <= pwdata[7:0];
        {2'b00, VDS_IDX_VRL}: vrl_reg <= pwdata[7:0];
        {2'b00, VDS_IDX_HRU}: hru_reg <= pwdata[7:0];
        {2'b00, VDS_IDX_HRL}: hrl_reg <= pwdata[7:0];
        {2'b00, VDS_IDX_VTC}: vtc_reg <= pwdata[7:0];
        {2'b00, VDS_IDX_SLC}: slc_reg <= pwdata[7:0];
        default: vtc_reg <= vtc_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ratio decode
  logic [15:0] h_ratio;
  logic [12:0] v_ratio, v_inc, v_inc_lim;
  logic [13:0] v_step;
  logic interlace, single_field, comb_en, fld_align, prefilt_en, peak_en;
  logic [1:0] tap_sel, hsel, tap_lim, taps_eff;

  assign h_ratio = ({hru_reg, hrl_reg} > VDS_H_MAX) ? VDS_H_MAX : {hru_reg, hrl_reg};
  assign v_ratio = {vru_reg[4:0], vrl_reg};
  assign v_inc = 13'h0000 - v_ratio;
  assign v_inc_lim = single_field ? VDS_V_MAX_FIELD : VDS_V_MAX_FRAME;
  assign v_step = VDS_V_UNIT + {1'b0, (v_inc > v_inc_lim) ? v_inc_lim : v_inc};
  assign interlace = vru_reg[VDS_BIT_INTERLACE];
  assign single_field = vru_reg[VDS_BIT_SINGLE];
  assign comb_en = vru_reg[VDS_BIT_COMB];
  assign tap_sel = vtc_reg[1:0];
  assign fld_align = vtc_reg[VDS_BIT_FLDALIGN];
  assign prefilt_en = vtc_reg[VDS_BIT_PREFILT];
  assign peak_en = slc_reg[VDS_BIT_PEAK];
  assign hsel = slc_reg[2:1];
  assign tap_lim = (h_ratio >= VDS_H_FOR_5) ? 2'd3 : (h_ratio >= VDS_H_FOR_4) ? 2'd2 :
                   (h_ratio >= VDS_H_FOR_3) ? 2'd1 : 2'd0;
  assign taps_eff = (tap_sel > tap_lim) ? tap_lim : tap_sel;

  ////////////////////////////////////////////////////////////////////////////
  // luma pre-filter and peaking, one pixel of delay
  logic [7:0] y0_reg, y1_reg, y2_reg, c0_reg, c1_reg;
  logic v0_reg, v1_reg, ls0_reg, ls1_reg;
  logic [9:0] lp_sum, pk_sum, tmp;
  logic signed [10:0] hp, pk;
  logic [7:0] y_pre;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y0_reg <= 8'h00;
      y1_reg <= 8'h00;
      y2_reg <= 8'h00;
      c0_reg <= 8'h00;
      c1_reg <= 8'h00;
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
      ls0_reg <= 1'b0;
      ls1_reg <= 1'b0;
    end else begin
      v0_reg <= in_valid;
      ls0_reg <= in_valid && in_line_start;
      if (in_valid) begin
        y0_reg <= in_luma;
        c0_reg <= in_chroma;
      end
      if (v0_reg) begin
        y1_reg <= y0_reg;
        y2_reg <= y1_reg;
        c1_reg <= c0_reg;
      end
      v1_reg <= v0_reg;
      ls1_reg <= ls0_reg;
    end
  end

  always_comb begin
    tmp = {2'b00, y1_reg};
    lp_sum = ({2'b00, y0_reg} + {1'b0, y1_reg, 1'b0} + {2'b00, y2_reg}) >> 2;
    hp = $signed({2'b00, y1_reg, 1'b0}) - $signed({3'b000, y0_reg}) - $signed({3'b000, y2_reg});
    pk = $signed({3'b000, y1_reg}) + (hp >>> (3'd4 - {1'b0, hsel}));
    pk_sum = pk[10] ? 10'h000 : (pk[9:8] != 2'b00) ? 10'h0FF : pk[9:0];
    if (peak_en) begin
      tmp = pk_sum;
    end else if (prefilt_en) begin
      tmp = lp_sum;
    end
    y_pre = tmp[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // horizontal polyphase scaler
  logic [23:0] tgt_reg;
  logic [10:0] n_reg;
  logic [7:0] yp_reg, cp_reg;
  logic [4:0] hph;
  logic h_fire;
  logic [7:0] h_y, h_c;

  function automatic logic [7:0] lerp32(input logic [7:0] a, input logic [7:0] b, input logic [4:0] ph);
    logic signed [9:0] d;
    logic signed [15:0] m;
    logic [15:0] s;
    d = $signed({2'b00, b}) - $signed({2'b00, a});
    m = d * $signed({1'b0, ph});
    s = 16'({8'h00, a}) + 16'(m >>> 5);
    return s[7:0];
  endfunction

  assign hph = tgt_reg[11:7];
  assign h_fire = v1_reg && (ls1_reg || tgt_reg[22:12] == n_reg);
  assign h_y = lerp32(y_pre, ls1_reg ? y_pre : yp_reg, ls1_reg ? 5'd0 : hph);
  assign h_c = lerp32(c1_reg, ls1_reg ? c1_reg : cp_reg, ls1_reg ? 5'd0 : hph);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_reg <= 24'h00_0000;
      n_reg <= 11'h000;
      yp_reg <= 8'h00;
      cp_reg <= 8'h00;
    end else if (v1_reg) begin
      yp_reg <= y_pre;
      cp_reg <= c1_reg;
      n_reg <= ls1_reg ? 11'h001 : n_reg + 11'h001;
      if (ls1_reg) begin
        tgt_reg <= VDS_H_UNIT + {8'h00, h_ratio};
      end else if (h_fire) begin
        tgt_reg <= tgt_reg + VDS_H_UNIT + {8'h00, h_ratio};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vertical line decision and counters
  logic [13:0] vacc_reg;
  logic emit_reg;
  logic odd_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vacc_reg <= 14'h0000;
      emit_reg <= 1'b0;
      odd_reg <= 1'b0;
      col_reg <= 10'h000;
      line_px_reg <= 10'h000;
      in_line_cnt_reg <= 10'h000;
      in_lines_reg <= 10'h000;
    end else begin
      if (in_valid && in_field_start) begin
        odd_reg <= in_field_odd;
        in_lines_reg <= in_line_cnt_reg;
        in_line_cnt_reg <= 10'h000;
        vacc_reg <= (fld_align && !interlace && in_field_odd) ? VDS_V_HALF : 14'h0000;
      end else if (ls1_reg) begin
        in_line_cnt_reg <= in_line_cnt_reg + 10'h001;
        emit_reg <= vacc_reg < VDS_V_UNIT;
        vacc_reg <= ((vacc_reg < VDS_V_UNIT) ? vacc_reg + v_step : vacc_reg) - VDS_V_UNIT;
      end
      if (ls1_reg) begin
        line_px_reg <= col_reg;
        col_reg <= 10'h001;
      end else if (h_fire && col_reg != 10'h3FF) begin
        col_reg <= col_reg + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line store, one shift per output column
  logic [7:0] lb [VDS_TAPS_MAX-1][VDS_LINE_DEPTH];
  logic [7:0] lbc [VDS_LINE_DEPTH];
  logic [7:0] tap [VDS_TAPS_MAX];
  logic [9:0] wcol;

  assign wcol = ls1_reg ? 10'h000 : col_reg;
  assign tap[0] = h_y;
  genvar gi;
  generate
    for (gi = 0; gi < VDS_TAPS_MAX - 1; gi++) begin : g_line
      assign tap[gi+1] = lb[gi][wcol];
      always_ff @(posedge pclk) begin
        if (h_fire) begin
          lb[gi][wcol] <= tap[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk) begin
    if (h_fire) begin
      lbc[wcol] <= h_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vertical filters and output
  logic [11:0] vsum;
  logic [7:0] vflt, vy, vc;
  logic [8:0] csum;

  always_comb begin
    case (taps_eff)
      2'd0: vsum = (12'(tap[0]) + 12'(tap[1])) << 3;
      2'd1: vsum = (12'(tap[0]) + (12'(tap[1]) << 1) + 12'(tap[2])) << 2;
      2'd2: vsum = (12'(tap[0]) + 12'(tap[1]) * 12'd3 + 12'(tap[2]) * 12'd3 + 12'(tap[3])) << 1;
      2'd3: vsum = 12'(tap[0]) + (12'(tap[1]) << 2) + 12'(tap[2]) * 12'd6 + (12'(tap[3]) << 2) + 12'(tap[4]);
      default: vsum = 12'(tap[0]) << 4;
    endcase
    vflt = vsum[11:4];
    csum = {1'b0, h_c} + {1'b0, lbc[wcol]};
    vc = comb_en ? csum[8:1] : h_c;
    if (interlace) begin
      vy = odd_reg ? lerp32(h_y, tap[1], 5'd16) : h_y;
    end else begin
      vy = lerp32(vflt, tap[1], vacc_reg[8:4]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_line_start <= 1'b0;
      out_luma <= 8'h00;
      out_chroma <= 8'h00;
    end else begin
      out_valid <= h_fire && (ls1_reg ? (vacc_reg < VDS_V_UNIT) : emit_reg);
      out_line_start <= h_fire && ls1_reg && (vacc_reg < VDS_V_UNIT);
      out_luma <= vy;
      out_chroma <= vc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  unity_pixels_a: assert property (@(posedge pclk) disable iff (!presetn)
    (v1_reg && h_ratio == 16'h0000) |-> h_fire)
    else $error("unscaled pixel not emitted");
  phase_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    h_fire && !ls1_reg |=> ##0 1'b1 ##0 (tgt_reg[11:0] == $past(tgt_reg[11:0]) + $past(h_ratio[11:0])))
    else $error("accumulator fraction step wrong");
  vert_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    single_field |-> v_step <= VDS_V_UNIT + {1'b0, VDS_V_MAX_FIELD})
    else $error("field ratio above 8:1");
  horiz_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    h_ratio <= VDS_H_MAX && v_step <= VDS_V_UNIT + {1'b0, VDS_V_MAX_FRAME})
    else $error("ratio above 16:1");
  tap_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (h_ratio < VDS_H_FOR_3) |-> taps_eff == 2'd0)
    else $error("too many taps for line width");
  drop_line_a: assert property (@(posedge pclk) disable iff (!presetn)
    (h_fire && !ls1_reg && !emit_reg) |=> !out_valid)
    else $error("dropped line produced pixels");
  chroma_comb_a: assert property (@(posedge pclk) disable iff (!presetn)
    (h_fire && comb_en) |=> out_chroma == $past(csum[8:1]))
    else $error("chroma comb result wrong");
  even_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (h_fire && interlace && !odd_reg) |=> out_luma == $past(h_y))
    else $error("unfiltered field altered");

endmodule

// [rtl/vds_pkg.sv]
// constants and register map of the video down-scaler
package vds_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] VDS_IDX_VRU = 8'h13;
  localparam logic [7:0] VDS_IDX_VRL = 8'h14;
  localparam logic [7:0] VDS_IDX_HRU = 8'h20;
  localparam logic [7:0] VDS_IDX_HRL = 8'h21;
  localparam logic [7:0] VDS_IDX_VTC = 8'h22;
  localparam logic [7:0] VDS_IDX_SLC = 8'h23;
  localparam logic [7:0] VDS_IDX_STA = 8'h24;
  // reset values
  localparam logic [7:0] VDS_RST_BYTE = 8'h00;
  localparam logic [1:0] VDS_RST_TAPS = 2'h0;
  // field positions
  localparam int VDS_BIT_INTERLACE = 5;
  localparam int VDS_BIT_SINGLE = 6;
  localparam int VDS_BIT_COMB = 7;
  localparam int VDS_BIT_FLDALIGN = 2;
  localparam int VDS_BIT_PREFILT = 3;
  localparam int VDS_BIT_PEAK = 0;
  // scaling arithmetic
  localparam logic [23:0] VDS_H_UNIT = 24'h00_1000;
  localparam logic [15:0] VDS_H_MAX = 16'hF000;
  localparam logic [13:0] VDS_V_UNIT = 14'h0200;
  localparam logic [12:0] VDS_V_MAX_FRAME = 13'h1E00;
  localparam logic [12:0] VDS_V_MAX_FIELD = 13'h0E00;
  localparam logic [13:0] VDS_V_HALF = 14'h0100;
  // line store
  localparam int VDS_LINE_DEPTH = 1024;
  localparam int VDS_TAPS_MAX = 5;
  // horizontal ratio thresholds that unlock more vertical taps
  localparam logic [15:0] VDS_H_FOR_3 = 16'h0800;
  localparam logic [15:0] VDS_H_FOR_4 = 16'h1000;
  localparam logic [15:0] VDS_H_FOR_5 = 16'h3000;
endpackage

// [dv/vds_src_model.sv]
// pixel source standing in for the upstream decoder front end
`timescale 1ns/10ps
module vds_src_model
  import vds_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the bench
  input wire logic go,
  input wire logic slow,
  input wire logic [10:0] ppl,
  input wire logic [7:0] nlines,
  output logic busy,
  // pixel stream
  output logic in_valid,
  output logic in_line_start,
  output logic in_field_start,
  output logic in_field_odd,
  output logic [7:0] in_luma,
  output logic [7:0] in_chroma
);
  logic [10:0] col_reg;
  logic [7:0] line_reg;
  logic pace_reg;
  logic odd_reg;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      col_reg <= 11'h0;
      line_reg <= 8'h0;
      pace_reg <= 1'b0;
      odd_reg <= 1'b0;
      in_valid <= 1'b0;
      in_line_start <= 1'b0;
      in_field_start <= 1'b0;
      in_field_odd <= 1'b0;
      in_luma <= 8'h00;
      in_chroma <= 8'h00;
    end else begin
      in_valid <= 1'b0;
      in_line_start <= 1'b0;
      in_field_start <= 1'b0;
      // idle data keeps toggling so stale pixels cannot pass
      in_luma <= ~in_luma;
      in_chroma <= ~in_chroma;
      if (go && !busy) begin
        busy <= 1'b1;
        col_reg <= 11'h0;
        line_reg <= 8'h0;
        pace_reg <= 1'b0;
        odd_reg <= ~odd_reg;
      end else if (busy) begin
        pace_reg <= slow ? ~pace_reg : 1'b0;
        if (!pace_reg) begin
          in_valid <= 1'b1;
          in_line_start <= (col_reg == 11'h0);
          in_field_start <= (col_reg == 11'h0) && (line_reg == 8'h0);
          in_field_odd <= odd_reg;
          in_luma <= col_reg[7:0];
          in_chroma <= ~col_reg[7:0];
          if (col_reg == ppl - 11'd1) begin
            col_reg <= 11'h0;
            line_reg <= line_reg + 8'd1;
            if (line_reg == nlines - 8'd1) begin
              busy <= 1'b0;
            end
          end else begin
            col_reg <= col_reg + 11'd1;
          end
        end
      end
    end
  end
endmodule

// [dv/tb.sv]
// self-checking testbench of the video down-scaler
`timescale 1ns/10ps
module tb;
  import vds_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, slow = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, in_valid, in_line_start, in_field_start, in_field_odd, out_valid, out_line_start, busy;
  logic [7:0] in_luma, in_chroma, out_luma, out_chroma, nl = 0;
  logic [10:0] ppl = 0;
  logic [7:0] ridx [7] = '{VDS_IDX_VRU, VDS_IDX_VRL, VDS_IDX_HRU, VDS_IDX_HRL, VDS_IDX_VTC, VDS_IDX_SLC, VDS_IDX_STA};
  int fails = 0, compares = 0, npix, nlin, cyc = 0, t_in, t_out;
  int ocol = 0;
  logic cchk = 1'b1, lchk = 1'b0;
  always #5 pclk = ~pclk;
  vds_scaler uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .in_valid, .in_line_start, .in_field_start, .in_field_odd, .in_luma, .in_chroma,
    .out_valid, .out_line_start, .out_luma, .out_chroma);
  vds_src_model src (.pclk, .presetn, .go, .slow, .ppl, .nlines(nl), .busy,
    .in_valid, .in_line_start, .in_field_start, .in_field_odd, .in_luma, .in_chroma);
  ////////////////////////////////////////////////////////////////
  always @(negedge pclk) begin
    cyc++;
    if (in_valid === 1'b1 && in_line_start === 1'b1 && t_in < 0) t_in = cyc;
    if (out_line_start === 1'b1 && t_out < 0) t_out = cyc;
    if (out_valid === 1'b1) npix++;
    if (out_line_start === 1'b1) nlin++;
    if (out_line_start === 1'b1) ocol = 0;
    if (out_valid === 1'b1 && cchk) chk(out_chroma, {24'h0, ~ocol[7:0]});
    if (out_valid === 1'b1 && lchk) chk(out_luma, ocol);
    if (out_valid === 1'b1) ocol++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q,
    output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) fails++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, idx, d, q, e);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic experr = 1'b0,
    input logic [31:0] m = 32'hFFFF_FFFF);
    logic e;
    apb(1'b0, idx, 32'h0, rd, e);
    chk(rd & m, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask
  task automatic set_vr(input logic [12:0] v);
    logic e;
    apb(1'b0, VDS_IDX_VRU, 32'h0, rd, e);
    wr(VDS_IDX_VRU, (rd & 32'h0000_00E0) | {27'h0, v[12:8]});
    wr(VDS_IDX_VRL, {24'h0, v[7:0]});
  endtask
  task automatic frame(input logic [10:0] p, input logic [7:0] l, input int ep, input int el);
    int n;
    npix = 0;
    nlin = 0;
    t_in = -1;
    t_out = -1;
    @(posedge pclk);
    ppl <= p;
    nl <= l;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy && n < 40000);
    if (n == 40000) fails++;
    repeat (8) @(posedge pclk);
    chk(npix, ep);
    chk(nlin, el);
    chk(t_out - t_in, 3);
    $display("frame test done: %0d pixels, %0d lines", npix, nlin);
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ridx[i]) rdchk(ridx[i], 32'h0);
    rdchk(8'h30, 32'h0, 1'b1);
    wr(VDS_IDX_VRU, 32'h0000_00FF);
    rdchk(VDS_IDX_VRU, 32'h0000_00FF);
    wr(VDS_IDX_HRL, 32'h0000_01A5);
    rdchk(VDS_IDX_HRL, 32'h0000_00A5);
    wr(VDS_IDX_STA, 32'h0000_0055);
    rdchk(VDS_IDX_STA, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(VDS_IDX_VTC, i);
      rdchk(VDS_IDX_VTC, i);
      wr(VDS_IDX_SLC, {i[6:0], 1'b1});
      rdchk(VDS_IDX_SLC, {i[6:0], 1'b1});
    end
    wr(VDS_IDX_VTC, 32'h0000_00FF);
    rdchk(VDS_IDX_VTC, 32'h0000_00FF);
    foreach (ridx[i]) wr(ridx[i], 32'h0);
    $display("register test done");
    frame(11'd910, 8'd1, 910, 1);
    cchk = 1'b0;
    wr(VDS_IDX_HRU, 32'h0000_0010);
    slow <= 1'b1;
    frame(11'd910, 8'd1, 455, 1);
    slow <= 1'b0;
    rdchk(VDS_IDX_STA, 32'd910, 1'b0, 32'h0000_03FF);
    wr(VDS_IDX_HRU, 32'h0000_00F0);
    frame(11'd910, 8'd1, 57, 1);
    wr(VDS_IDX_HRU, 32'h0000_00FF);
    wr(VDS_IDX_HRL, 32'h0000_00FF);
    frame(11'd910, 8'd1, 57, 1);
    wr(VDS_IDX_HRU, 32'h0);
    wr(VDS_IDX_HRL, 32'h0);
    cchk = 1'b1;
    set_vr(13'h1E00);
    frame(11'd16, 8'd8, 64, 4);
    set_vr(13'h0200);
    frame(11'd16, 8'd16, 16, 1);
    wr(VDS_IDX_VRU, 32'h0000_0040);
    set_vr(13'h0200);
    rdchk(VDS_IDX_VRU, 32'h0000_0042);
    frame(11'd16, 8'd16, 32, 2);
    rdchk(VDS_IDX_STA, 32'h0010_0000, 1'b0, 32'h03FF_0000);
    wr(VDS_IDX_VRU, 32'h0000_00A0);
    lchk = 1'b1;
    frame(11'd16, 8'd2, 32, 2);
    tally_and_finish();
  end
  initial begin
    #600000;
    fails++;
    tally_and_finish();
  end
endmodule
